// *** logic/reg_bank.sv ***
// small register store written and read by the packet framer
// assumes single clock domain; read data registered one cycle after rd_en_i
module reg_bank (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input spi_framer_pkg::wr_req_t wr_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic [spi_framer_pkg::REG_COUNT*8-1:0] regs_o
);
   logic [7:0] mem [spi_framer_pkg::REG_COUNT];
   logic [7:0] next_mem [spi_framer_pkg::REG_COUNT];
   logic [7:0] rd_data;
   logic [7:0] next_rd_data;

   always_comb begin
      for (int i = 0; i < spi_framer_pkg::REG_COUNT; i++) begin
         next_mem[i] = mem[i];
         regs_o[i*8 +: 8] = mem[i];
      end
      next_rd_data = rd_data;
      if (ce_i && wr_en_i && spi_framer_pkg::addr_mapped(wr_i.addr)) begin
         next_mem[wr_i.addr[spi_framer_pkg::REG_IDX_W-1:0]] = wr_i.data;
      end
      if (ce_i && rd_en_i) begin
         next_rd_data = spi_framer_pkg::addr_mapped(rd_addr_i) ?
            mem[rd_addr_i[spi_framer_pkg::REG_IDX_W-1:0]] : spi_framer_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < spi_framer_pkg::REG_COUNT; i++) begin
            mem[i] <= spi_framer_pkg::REG_RESET;
         end
         rd_data <= spi_framer_pkg::BYTE_ZERO;
      end else begin
         mem <= next_mem;
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_o = rd_data;

   AST_UNMAPPED_WRITE: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ce_i && wr_en_i && !spi_framer_pkg::addr_mapped(wr_i.addr) |=> $stable(regs_o))
      else $error("write to unmapped address changed a register");

   AST_UNMAPPED_READ: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ce_i && rd_en_i && !spi_framer_pkg::addr_mapped(rd_addr_i) |=> rd_data_o == 8'h00)
      else $error("read of unmapped address returned nonzero data");
endmodule

// *** logic/spi_framer_pkg.sv ***
// shared constants, types and helpers for the three-byte spi packet framer
// assumes one master frames every byte with chip-select, msb first
package spi_framer_pkg;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [3:0] BIT_CNT_OVER = 4'h9;
   localparam logic [3:0] CID_FIRST_CNT = 4'h4;
   localparam logic [3:0] CID_LAST_CNT = 4'h7;
   localparam int BCST_BIT = 7;
   localparam int DIR_BIT = 6;
   localparam int RSV_HI_BIT = 5;
   localparam int RSV_LO_BIT = 4;
   localparam int CID_HI_BIT = 3;
   localparam int REG_COUNT = 8;
   localparam int REG_IDX_W = 3;
   localparam logic [7:0] REG_LIMIT = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {POS_CONTROL, POS_ADDRESS, POS_DATA} byte_pos_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_t;

   // received id field of zero means this device is the one addressed
   function automatic logic chain_target(input logic [7:0] ctrl);
      return ctrl[CID_HI_BIT:0] == 4'h0;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] addr);
      return addr < REG_LIMIT;
   endfunction

   function automatic byte_pos_t pos_after(input byte_pos_t pos);
      byte_pos_t nxt;
      unique case (pos)
         POS_CONTROL: nxt = POS_ADDRESS;
         POS_ADDRESS: nxt = POS_DATA;
         POS_DATA: nxt = POS_CONTROL;
      endcase
      return nxt;
   endfunction
endpackage

// *** logic/spi_packet_framer.sv ***
// spi slave framer: three-byte packets, byte framed by chip-select, daisy chain
// assumes sclk_i idles low between bytes; register side runs on clock_i
module spi_packet_framer (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic chain_forward_out_o,
   input wire logic [7:0] status_i,
   output logic [spi_framer_pkg::REG_COUNT*8-1:0] regs_o,
   output logic write_strobe_o,
   output logic packet_dropped_o
);
   // link state, clocked by sclk_i
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   spi_framer_pkg::byte_pos_t pos;
   spi_framer_pkg::byte_pos_t next_pos;
   logic discard;
   logic next_discard;
   logic seen_tog;
   logic next_seen_tog;
   logic borrow;
   logic next_borrow;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [7:0] addr;
   logic [7:0] next_addr;
   logic rd_tog;
   logic next_rd_tog;
   // frame-end state, clocked by chip-select rise
   logic cs_tog;
   logic next_cs_tog;
   logic commit_tog;
   logic next_commit_tog;
   spi_framer_pkg::wr_req_t commit;
   spi_framer_pkg::wr_req_t next_commit;
   // register side, clocked by clock_i
   logic [2:0] commit_sync;
   logic [2:0] next_commit_sync;
   logic [2:0] rd_sync;
   logic [2:0] next_rd_sync;
   logic [1:0] drop_sync;
   logic [1:0] next_drop_sync;
   logic rd_pending;
   logic next_rd_pending;
   logic [7:0] rd_hold;
   logic [7:0] next_rd_hold;
   logic [7:0] bank_rdata;
   // combinational helpers
   logic frame_edge;
   logic byte_ok;
   logic [3:0] cur_cnt;
   spi_framer_pkg::byte_pos_t cur_pos;
   logic cur_discard;
   logic [7:0] rx_byte;
   logic cid_window;
   logic is_target;
   logic is_read;
   logic drive;
   logic commit_pulse;
   logic rd_pulse;

   // a chip-select rise since the last clock edge marks a new byte
   assign frame_edge = cs_tog ^ seen_tog;
   assign byte_ok = bit_cnt == spi_framer_pkg::BIT_CNT_FULL;
   assign rx_byte = {shreg[6:0], mosi_i};
   assign is_target = spi_framer_pkg::chain_target(ctrl);
   assign is_read = ctrl[spi_framer_pkg::DIR_BIT];

   always_comb begin
      cur_cnt = bit_cnt;
      cur_pos = pos;
      cur_discard = discard;
      if (frame_edge) begin
         cur_cnt = spi_framer_pkg::BIT_CNT_ZERO;
         if (byte_ok) begin
            cur_pos = spi_framer_pkg::pos_after(pos);
            if (pos == spi_framer_pkg::POS_DATA) begin
               cur_discard = 1'b0;
            end
         end else begin
            cur_discard = 1'b1;
         end
      end
   end

   // id field arrives low bit first, so a serial borrow ripples upward
   assign cid_window = !cs_n_i && cur_pos == spi_framer_pkg::POS_CONTROL &&
      cur_cnt >= spi_framer_pkg::CID_FIRST_CNT && cur_cnt <= spi_framer_pkg::CID_LAST_CNT;
   // pass-through is combinational, so chain length limits the clock rate
   assign chain_forward_out_o = mosi_i ^ (cid_window & borrow);

   always_comb begin
      next_bit_cnt = bit_cnt;
      next_pos = pos;
      next_discard = discard;
      next_seen_tog = cs_tog;
      next_borrow = borrow;
      next_shreg = shreg;
      next_ctrl = ctrl;
      next_addr = addr;
      next_rd_tog = rd_tog;
      if (cs_n_i) begin
         next_bit_cnt = spi_framer_pkg::BIT_CNT_ZERO;
         next_pos = spi_framer_pkg::POS_CONTROL;
         next_discard = 1'b0;
         next_borrow = 1'b1;
      end else begin
         next_shreg = rx_byte;
         next_pos = cur_pos;
         next_discard = cur_discard;
         // saturate so an overlong byte never looks complete
         next_bit_cnt = (cur_cnt == spi_framer_pkg::BIT_CNT_OVER) ? cur_cnt : cur_cnt + 4'h1;
         next_borrow = cid_window ? (borrow & ~mosi_i) : 1'b1;
         if (cur_cnt == spi_framer_pkg::BIT_CNT_LAST) begin
            unique case (cur_pos)
               spi_framer_pkg::POS_CONTROL: next_ctrl = rx_byte;
               spi_framer_pkg::POS_ADDRESS: begin
                  next_addr = rx_byte;
                  // broadcast bit plays no part in a read
                  if (is_read && is_target && !cur_discard) begin
                     next_rd_tog = ~rd_tog;
                  end
               end
               spi_framer_pkg::POS_DATA: next_ctrl = ctrl;
            endcase
         end
      end
   end

   always_ff @(posedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_cnt <= spi_framer_pkg::BIT_CNT_ZERO;
         pos <= spi_framer_pkg::POS_CONTROL;
         discard <= 1'b0;
         seen_tog <= 1'b0;
         borrow <= 1'b1;
         shreg <= spi_framer_pkg::BYTE_ZERO;
         ctrl <= spi_framer_pkg::BYTE_ZERO;
         addr <= spi_framer_pkg::BYTE_ZERO;
         rd_tog <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         pos <= next_pos;
         discard <= next_discard;
         seen_tog <= next_seen_tog;
         borrow <= next_borrow;
         shreg <= next_shreg;
         ctrl <= next_ctrl;
         addr <= next_addr;
         rd_tog <= next_rd_tog;
      end
   end

   // read data held stable by the handshake before the data byte starts
   assign drive = !cs_n_i && cur_pos == spi_framer_pkg::POS_DATA && is_read && is_target &&
      !cur_discard;
   assign miso_oe_o = drive;
   assign miso_o = (drive && cur_cnt < spi_framer_pkg::BIT_CNT_FULL) ?
      rd_hold[3'h7 - cur_cnt[2:0]] : 1'b0;

   // write commits only on a clean chip-select rise after exactly eight bits
   always_comb begin
      next_cs_tog = ~cs_tog;
      next_commit_tog = commit_tog;
      next_commit = commit;
      if (byte_ok && pos == spi_framer_pkg::POS_DATA && !discard && !is_read &&
         (ctrl[spi_framer_pkg::BCST_BIT] || is_target)) begin
         next_commit_tog = ~commit_tog;
         next_commit = '{addr: addr, data: shreg};
      end
   end

   always_ff @(posedge cs_n_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cs_tog <= 1'b0;
         commit_tog <= 1'b0;
         commit <= '{addr: spi_framer_pkg::BYTE_ZERO, data: spi_framer_pkg::BYTE_ZERO};
      end else begin
         cs_tog <= next_cs_tog;
         commit_tog <= next_commit_tog;
         commit <= next_commit;
      end
   end

   assign commit_pulse = commit_sync[2] ^ commit_sync[1];
   assign rd_pulse = rd_sync[2] ^ rd_sync[1];

   always_comb begin
      next_commit_sync = commit_sync;
      next_rd_sync = rd_sync;
      next_drop_sync = drop_sync;
      next_rd_pending = rd_pending;
      next_rd_hold = rd_hold;
      if (ce_i) begin
         next_commit_sync = {commit_sync[1:0], commit_tog};
         next_rd_sync = {rd_sync[1:0], rd_tog};
         next_drop_sync = {drop_sync[0], discard};
         next_rd_pending = rd_pulse;
         if (rd_pending) begin
            next_rd_hold = (addr == spi_framer_pkg::STATUS_ADDR) ? status_i : bank_rdata;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         commit_sync <= 3'h0;
         rd_sync <= 3'h0;
         drop_sync <= 2'h0;
         rd_pending <= 1'b0;
         rd_hold <= spi_framer_pkg::BYTE_ZERO;
      end else begin
         commit_sync <= next_commit_sync;
         rd_sync <= next_rd_sync;
         drop_sync <= next_drop_sync;
         rd_pending <= next_rd_pending;
         rd_hold <= next_rd_hold;
      end
   end

   assign write_strobe_o = commit_pulse & ce_i;
   assign packet_dropped_o = drop_sync[1];

   reg_bank bank (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wr_en_i(commit_pulse),
      .wr_i(commit),
      .rd_en_i(rd_pulse),
      .rd_addr_i(addr),
      .rd_data_o(bank_rdata),
      .regs_o(regs_o)
   );

   sequence s_read_req;
      ce_i && rd_pulse && addr != spi_framer_pkg::STATUS_ADDR &&
         !spi_framer_pkg::addr_mapped(addr);
   endsequence

   sequence s_hold_zero;
      ##2 rd_hold == 8'h00;
   endsequence

   AST_READ_ZERO: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_read_req ##1 ce_i |-> s_hold_zero)
      else $error("unmapped read did not return zero");

   AST_RESYNC: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      cs_n_i |=> pos == spi_framer_pkg::POS_CONTROL && bit_cnt == 4'h0 && !discard)
      else $error("clock while deselected did not restart the packet");

   AST_OUT_ONLY_DATA: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      miso_oe_o |-> !cs_n_i && cur_pos == spi_framer_pkg::POS_DATA && ctrl[6])
      else $error("serial output driven outside read data byte");

   AST_FWD_PLAIN: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      !cid_window |-> chain_forward_out_o == mosi_i)
      else $error("non-id bit altered on pass-through");

   AST_ID_ZERO_WRAP: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      cid_window && cur_cnt == 4'h4 |-> chain_forward_out_o == !mosi_i)
      else $error("id low bit not inverted by decrement");

   AST_COUNT_SAT: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      bit_cnt == 4'h9 && !cs_n_i && !frame_edge |=> bit_cnt == 4'h9)
      else $error("bit counter left saturation inside an overlong byte");

   AST_READ_TARGET: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      rd_tog != $past(rd_tog) |-> ctrl[3:0] == 4'h0 && ctrl[6])
      else $error("read started for a device that was not addressed");

   AST_ADVANCE: assert property (@(posedge sclk_i) disable iff (!resetn_i)
      !cs_n_i && frame_edge && byte_ok && pos == spi_framer_pkg::POS_CONTROL
      |=> pos == spi_framer_pkg::POS_ADDRESS)
      else $error("complete control byte did not advance position");

   AST_WRITE_LANDS: assert property (@(posedge clock_i) disable iff (!resetn_i)
      ce_i && commit_pulse && spi_framer_pkg::addr_mapped(commit.addr)
      |=> regs_o[commit.addr[2:0]*8 +: 8] == commit.data)
      else $error("committed write did not reach its register");
endmodule

// *** verif/spi_master_model.sv ***
// behavioural spi master on the framer's serial side, one byte per select window
// assumes sclk idles low and toggles only inside a frame or a resync pulse
module spi_master_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_i,
   input wire logic fwd_i
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 6;
   logic last_miso;
   wire logic miso_line;
   // no pull resistor: a released line toggles so stale data never matches
   assign miso_line = miso_oe_i ? miso_i : ~last_miso;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      last_miso = 1'b0;
   end
   always @(posedge sclk_o) last_miso <= miso_line;
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
         output logic [7:0] fwd, output logic oe_seen);
      rx = 8'h00;
      fwd = 8'h00;
      oe_seen = 1'b0;
      cs_n_o = 1'b0;
      #(HALF);
      for (int i = 0; i < nbits; i++) begin
         // clocks past the eighth send zero, for the overlong-byte case
         mosi_o = (i < 8) ? tx[7 - i] : 1'b0;
         #(HALF);
         rx = {rx[6:0], miso_line};
         fwd = {fwd[6:0], fwd_i};
         oe_seen = oe_seen | miso_oe_i;
         sclk_o = 1'b1;
         #(HALF);
         sclk_o = 1'b0;
      end
      #(HALF);
      cs_n_o = 1'b1;
      // long gap: read data needs time to cross into the clock_i side
      #(8 * HALF);
   endtask
   task automatic resync();
      cs_n_o = 1'b1;
      #(HALF);
      sclk_o = 1'b1;
      #(HALF);
      sclk_o = 1'b0;
      #(8 * HALF);
   endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the three-byte spi packet framer
// assumes the master model owns sclk at 12 ns; clock_i runs at 4 ns
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, resetn, ce, sclk, cs_n, mosi, miso, miso_oe, fwd, strobe, dropped;
   logic [7:0] status;
   logic [63:0] regs;
   logic [63:0] exp_regs;
   logic [7:0] fwd_b [3];
   logic oe_b [3];
   int error_cnt = 0;
   int check_count = 0;
   int strobe_cnt = 0;
   spi_packet_framer dut (.clock_i(clock), .resetn_i(resetn), .ce_i(ce),
      .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_o(miso_oe), .chain_forward_out_o(fwd), .status_i(status),
      .regs_o(regs), .write_strobe_o(strobe), .packet_dropped_o(dropped));
   spi_master_model mst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso), .miso_oe_i(miso_oe), .fwd_i(fwd));
   always #2 clock = ~clock;
   always @(posedge clock) if (strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t ns %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [7:0] fwd_exp(input logic [7:0] c);
      logic [3:0] id;
      id = {c[0], c[1], c[2], c[3]} - 4'h1;
      return {c[7:4], id[0], id[1], id[2], id[3]};
   endfunction
   task automatic pkt(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] dat,
         input int nlast, output logic [7:0] rx);
      logic [7:0] r;
      mst.xfer(ctl, 8, r, fwd_b[0], oe_b[0]);
      mst.xfer(adr, 8, r, fwd_b[1], oe_b[1]);
      mst.xfer(dat, nlast, rx, fwd_b[2], oe_b[2]);
      check(fwd_b[0], fwd_exp(ctl), "control passed along");
      check(fwd_b[1], adr, "address passed along");
   endtask
   task automatic wr(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] dat);
      logic [7:0] rx;
      logic hit;
      int n0;
      n0 = strobe_cnt;
      hit = ctl[7] || ctl[3:0] == 4'h0;
      pkt(ctl, adr, dat, 8, rx);
      if (hit && adr < 8'h08) exp_regs[adr[2:0] * 8 +: 8] = dat;
      check(regs, exp_regs, "register bank");
      check(64'(strobe_cnt - n0), {63'h0, hit}, "write strobes");
      check({oe_b[0], oe_b[1], oe_b[2], miso_oe}, 4'h0, "enable in write");
      check(fwd_b[2], dat, "data passed along");
   endtask
   task automatic rd(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] exp);
      logic [7:0] rx;
      pkt(ctl, adr, 8'h00, 8, rx);
      check(rx, exp, "read data");
      check({oe_b[0], oe_b[1], oe_b[2], miso_oe}, 4'h2, "enable in read");
   endtask
   task automatic tend(input string name);
      $display("test %s done, checks %0d, errors %0d", name, check_count, error_cnt);
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #(20000);
      error_cnt++;
      $display("[ERR] %0t ns watchdog expired", $time);
      give_verdict();
   end
   initial begin
      logic [7:0] r;
      logic [7:0] f;
      logic o;
      clock = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      status = 8'h5a;
      exp_regs = 64'h0;
      repeat (2) @(posedge clock);
      #1 resetn = 1'b1;
      check(regs, exp_regs, "registers after reset");
      // control bits 5:4 always zero from this master
      wr(8'h00, 8'h02, 8'ha5);
      rd(8'h40, 8'h02, 8'ha5);
      wr(8'h00, 8'h07, 8'h3c);
      rd(8'h40, 8'h07, 8'h3c);
      tend("write and read");
      wr(8'h00, 8'h20, 8'hff);
      rd(8'h40, 8'h0f, 8'h5a);
      rd(8'h40, 8'h10, 8'h00);
      tend("unmapped addresses");
      wr(8'h0c, 8'h03, 8'h11);
      wr(8'h8c, 8'h03, 8'h22);
      rd(8'hc0, 8'h03, 8'h22);
      tend("chain and broadcast");
      pkt(8'h00, 8'h04, 8'h77, 4, r);
      check(regs, exp_regs, "abandoned write");
      // a cut byte is only noticed at the first clock of the next byte
      mst.xfer(8'h00, 8, r, f, o);
      check(regs, exp_regs, "byte after cut packet");
      check(dropped, 1'b1, "drop flag set");
      mst.resync();
      check(dropped, 1'b0, "drop flag cleared");
      wr(8'h00, 8'h04, 8'h77);
      mst.xfer(8'h00, 8, r, f, o);
      mst.resync();
      rd(8'h40, 8'h04, 8'h77);
      tend("abort and resync");
      pkt(8'h00, 8'h05, 8'h99, 10, r);
      check(regs, exp_regs, "overlong write kept out");
      mst.resync();
      wr(8'h00, 8'h05, 8'h99);
      tend("overlong byte");
      @(posedge clock);
      #1 ce = 1'b0;
      pkt(8'h00, 8'h06, 8'h5c, 8, r);
      check(regs, exp_regs, "register side frozen");
      @(posedge clock);
      #1 ce = 1'b1;
      repeat (4) @(posedge clock);
      exp_regs[6 * 8 +: 8] = 8'h5c;
      check(regs, exp_regs, "write after enable");
      tend("clock enable");
      give_verdict();
   end
endmodule
